// *** hdl/frame_check_pkg.sv ***
`default_nettype none
package frame_check_pkg;
    // Clock and line silence
    localparam int CLK_PERIOD_NS = 40;
    localparam int GAP_TIME_NS = 10_000_000;
    localparam int GAP_CYCLES = GAP_TIME_NS / CLK_PERIOD_NS;
    localparam int IDLE_W = 20;
    // Binary check
    localparam logic [15:0] CRC_PRESET = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [3:0] CRC_STEPS = 4'h8;
    // Text framing and hex digit characters, binary minimum frame length
    localparam logic [7:0] CHAR_START = 8'h3a;
    localparam logic [7:0] CHAR_CR = 8'h0d;
    localparam logic [7:0] CHAR_LF = 8'h0a;
    localparam logic [7:0] CHAR_ZERO = 8'h30;
    localparam logic [7:0] CHAR_A_UP = 8'h41;
    localparam logic [7:0] CHAR_A_LO = 8'h61;
    localparam logic [1:0] RTU_MIN_BYTES = 2'h3;

    // Upper case hex character for one nibble
    function automatic logic [7:0] nib_to_hex(input logic [3:0] nib);
        if (nib < 4'ha) begin
            return CHAR_ZERO + {4'h0, nib};
        end
        return CHAR_A_UP + {4'h0, nib} - 8'h0a;
    endfunction : nib_to_hex

    // Returns {valid, nibble}
    function automatic logic [4:0] hex_to_nib(input logic [7:0] c);
        if (c >= CHAR_ZERO && c < CHAR_ZERO + 8'h0a) begin
            return {1'b1, 4'(c - CHAR_ZERO)};
        end
        if (c >= CHAR_A_UP && c < CHAR_A_UP + 8'h06) begin
            return {1'b1, 4'(c - CHAR_A_UP + 8'h0a)};
        end
        if (c >= CHAR_A_LO && c < CHAR_A_LO + 8'h06) begin
            return {1'b1, 4'(c - CHAR_A_LO + 8'h0a)};
        end
        return 5'h00;
    endfunction : hex_to_nib
endpackage : frame_check_pkg
`default_nettype wire

// *** hdl/crc16_byte_engine.sv ***
`default_nettype none
module crc16_byte_engine (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic busy,
    output logic [15:0] crc
);
    typedef struct packed {
        logic [15:0] crc;
        logic [3:0] steps;
    } crc_st_t;

    crc_st_t st_q, st_d;
    logic [15:0] base;

    always_comb begin
        st_d = st_q;
        base = clear ? frame_check_pkg::CRC_PRESET : st_q.crc;
        st_d.crc = base;
        if (byte_valid && st_q.steps == 4'h0) begin
            st_d.crc = {base[15:8], base[7:0] ^ byte_data};
            st_d.steps = frame_check_pkg::CRC_STEPS;
        end else if (st_q.steps != 4'h0) begin
            st_d.crc = (st_q.crc >> 1)
                ^ (st_q.crc[0] ? frame_check_pkg::CRC_POLY : 16'h0000);
            st_d.steps = st_q.steps - 4'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{crc: frame_check_pkg::CRC_PRESET, steps: 4'h0};
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = st_q.steps != 4'h0;
    assign crc = st_q.crc;

    ////////////////////////////////////////////////////////////////////
    sequence s_byte_in;
        byte_valid && !busy;
    endsequence
    AST_CRC_EIGHT: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_byte_in |=> busy [*8] ##1 !busy)
        else $error("byte did not take eight shift steps");
    AST_CRC_PRESET: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clear && !byte_valid && !busy
        |=> crc == frame_check_pkg::CRC_PRESET)
        else $error("accumulator not preset to all ones");
endmodule : crc16_byte_engine
`default_nettype wire

// *** hdl/two_entry_buffer.sv ***
`default_nettype none
module two_entry_buffer #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    // Output word plus one spare; ready is a flop so no comb path back
    typedef struct packed {
        logic o_v;
        logic [WIDTH-1:0] o_d;
        logic s_v;
        logic [WIDTH-1:0] s_d;
    } buf_st_t;

    buf_st_t st_q, st_d;
    logic take;

    always_comb begin
        st_d = st_q;
        take = in_valid && !st_q.s_v;
        if (!st_q.o_v || out_ready) begin
            if (st_q.s_v) begin
                st_d.o_d = st_q.s_d;
                st_d.o_v = 1'b1;
                st_d.s_v = 1'b0;
            end else begin
                st_d.o_v = take;
                st_d.o_d = in_data;
            end
        end else if (take) begin
            st_d.s_v = 1'b1;
            st_d.s_d = in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign in_ready = !st_q.s_v;
    assign out_valid = st_q.o_v;
    assign out_data = st_q.o_d;

    ////////////////////////////////////////////////////////////////////
    AST_BUF_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled word changed or vanished");
    AST_BUF_FULL: assert property (@(posedge ref_clk) disable iff (!rst_n)
        out_valid && !out_ready && in_valid && in_ready |=> !in_ready)
        else $error("buffer full but still ready");
endmodule : two_entry_buffer
`default_nettype wire

// *** hdl/serial_frame_check_unit.sv ***
`default_nettype none
module serial_frame_check_unit #(
    parameter int GAP_CYCLES = frame_check_pkg::GAP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ascii_mode,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte_data,
    output logic frame_good,
    output logic frame_error,
    input wire logic tx_in_valid,
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_last,
    output logic tx_in_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready
);
    localparam int W = frame_check_pkg::IDLE_W;
    localparam logic [W-1:0] GAP_LIM = W'(GAP_CYCLES);

    typedef enum logic [3:0] {
        T_IDLE, T_TAKE, T_HI, T_LO, T_RAW, T_CRC_WAIT, T_CRC_L, T_CRC_H,
        T_CK_HI, T_CK_LO, T_CR, T_LF
    } tx_state_t;

    typedef struct packed {
        tx_state_t ts;
        logic in_rdy;
        logic [7:0] tb;
        logic tl;
        logic [7:0] tsum;
        logic [W-1:0] tidle;
        logic ra;
        logic rhh;
        logic [3:0] rhi;
        logic [7:0] rsum;
        logic rcr;
        logic [1:0] rcnt;
        logic [W-1:0] ridle;
        logic ob_v;
        logic [7:0] ob_d;
        logic good;
        logic err;
    } unit_st_t;

    unit_st_t st_q, st_d;
    logic buf_in_valid, buf_in_ready;
    logic [7:0] buf_in_data;
    logic accept, push;
    logic [7:0] ck;
    logic [4:0] hx;
    logic rx_clr, tx_clr, rx_busy, tx_busy;
    logic [15:0] rx_crc, tx_crc;

    ////////////////////////////////////////////////////////////////////
    crc16_byte_engine rx_crc_i (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(rx_clr),
        .byte_valid(rx_valid && !ascii_mode),
        .byte_data(rx_data),
        .busy(rx_busy),
        .crc(rx_crc)
    );

    crc16_byte_engine tx_crc_i (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clear(tx_clr),
        .byte_valid(accept && !ascii_mode),
        .byte_data(tx_in_data),
        .busy(tx_busy),
        .crc(tx_crc)
    );

    // Stall by the UART reaches the framer through buf_in_ready
    two_entry_buffer #(.WIDTH(8)) tx_buf_i (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(buf_in_valid),
        .in_data(buf_in_data),
        .in_ready(buf_in_ready),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready)
    );

    // rx preset at first byte of frame, tx preset while idle before it
    assign rx_clr = !ascii_mode && rx_valid && !st_q.ra;
    assign tx_clr = !ascii_mode && st_q.ts == T_IDLE;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        st_d.ob_v = 1'b0;
        st_d.good = 1'b0;
        st_d.err = 1'b0;
        hx = frame_check_pkg::hex_to_nib(rx_data);
        // Receive side
        if (ascii_mode) begin
            st_d.ridle = '0;
            if (rx_valid) begin
                if (rx_data == frame_check_pkg::CHAR_START) begin
                    st_d.ra = 1'b1;
                    st_d.rsum = 8'h00;
                    st_d.rhh = 1'b0;
                    st_d.rcr = 1'b0;
                    st_d.rcnt = 2'h0;
                end else if (!st_q.ra) begin
                    st_d.ra = 1'b0;
                end else if (st_q.rcr) begin
                    st_d.ra = 1'b0;
                    // sum incl. check must be zero
                    if (rx_data == frame_check_pkg::CHAR_LF && !st_q.rhh
                        && st_q.rcnt != 2'h0 && st_q.rsum == 8'h00) begin
                        st_d.good = 1'b1;
                    end else begin
                        st_d.err = 1'b1;
                    end
                end else if (rx_data == frame_check_pkg::CHAR_CR) begin
                    st_d.rcr = 1'b1;
                end else if (hx[4] && st_q.rhh) begin
                    // modulo 256 sum of byte pairs
                    st_d.rsum = st_q.rsum + {st_q.rhi, hx[3:0]};
                    st_d.ob_v = 1'b1;
                    st_d.ob_d = {st_q.rhi, hx[3:0]};
                    st_d.rhh = 1'b0;
                    st_d.rcnt = 2'h1;
                end else if (hx[4]) begin
                    st_d.rhi = hx[3:0];
                    st_d.rhh = 1'b1;
                end else begin
                    st_d.ra = 1'b0;
                    st_d.err = 1'b1;
                end
            end
        end else if (rx_valid) begin
            // every frame byte out; into the check only when the CRC engine is not busy
            st_d.ra = 1'b1;
            st_d.ridle = '0;
            st_d.ob_v = 1'b1;
            st_d.ob_d = rx_data;
            st_d.rcnt = st_q.ra ? (st_q.rcnt == 2'h3 ? 2'h3 : st_q.rcnt + 2'h1)
                                : 2'h1;
        end else if (st_q.ra) begin
            st_d.ridle = st_q.ridle + W'(1);
            // gap reaching the limit (ridle >= GAP_LIM) closes frame
            if (st_q.ridle >= GAP_LIM) begin
                st_d.ra = 1'b0;
                if (!rx_busy && rx_crc == 16'h0000
                    && st_q.rcnt >= frame_check_pkg::RTU_MIN_BYTES) begin
                    st_d.good = 1'b1;
                end else begin
                    st_d.err = 1'b1;
                end
            end
        end
        // Transmit side
        accept = st_q.ts == T_TAKE && st_q.in_rdy && tx_in_valid;
        ck = 8'h00 - st_q.tsum;
        buf_in_valid = 1'b0;
        buf_in_data = 8'h00;
        unique case (st_q.ts)
            T_IDLE: begin
                buf_in_valid = ascii_mode && tx_in_valid;
                buf_in_data = frame_check_pkg::CHAR_START;
            end
            T_TAKE: begin
            end
            T_HI: begin
                buf_in_valid = 1'b1;
                buf_in_data = frame_check_pkg::nib_to_hex(st_q.tb[7:4]);
            end
            T_LO: begin
                buf_in_valid = 1'b1;
                buf_in_data = frame_check_pkg::nib_to_hex(st_q.tb[3:0]);
            end
            T_RAW: begin
                buf_in_valid = !tx_busy;
                buf_in_data = st_q.tb;
            end
            T_CRC_WAIT: begin
            end
            T_CRC_L: begin
                buf_in_valid = 1'b1;
                buf_in_data = tx_crc[7:0];
            end
            T_CRC_H: begin
                buf_in_valid = 1'b1;
                buf_in_data = tx_crc[15:8];
            end
            T_CK_HI: begin
                buf_in_valid = 1'b1;
                buf_in_data = frame_check_pkg::nib_to_hex(ck[7:4]);
            end
            T_CK_LO: begin
                buf_in_valid = 1'b1;
                buf_in_data = frame_check_pkg::nib_to_hex(ck[3:0]);
            end
            T_CR: begin
                buf_in_valid = 1'b1;
                buf_in_data = frame_check_pkg::CHAR_CR;
            end
            T_LF: begin
                buf_in_valid = 1'b1;
                buf_in_data = frame_check_pkg::CHAR_LF;
            end
        endcase
        push = buf_in_valid && buf_in_ready;
        if (push) begin
            st_d.tidle = '0;
        end else if (st_q.tidle <= GAP_LIM) begin
            st_d.tidle = st_q.tidle + W'(1);
        end
        unique case (st_q.ts)
            T_IDLE: begin
                st_d.tsum = 8'h00;
                if (ascii_mode ? push
                    : (tx_in_valid && st_q.tidle > GAP_LIM)) begin
                    st_d.ts = T_TAKE;
                end
            end
            T_TAKE: begin
                if (accept) begin
                    st_d.tb = tx_in_data;
                    st_d.tl = tx_in_last;
                    st_d.tsum = st_q.tsum + tx_in_data;
                    st_d.ts = ascii_mode ? T_HI : T_RAW;
                end
            end
            T_HI: st_d.ts = push ? T_LO : T_HI;
            T_LO: st_d.ts = push ? (st_q.tl ? T_CK_HI : T_TAKE) : T_LO;
            T_RAW: st_d.ts = push ? (st_q.tl ? T_CRC_WAIT : T_TAKE) : T_RAW;
            T_CRC_WAIT: st_d.ts = tx_busy ? T_CRC_WAIT : T_CRC_L;
            T_CRC_L: st_d.ts = push ? T_CRC_H : T_CRC_L;
            T_CRC_H: st_d.ts = push ? T_IDLE : T_CRC_H;
            T_CK_HI: st_d.ts = push ? T_CK_LO : T_CK_HI;
            T_CK_LO: st_d.ts = push ? T_CR : T_CK_LO;
            T_CR: st_d.ts = push ? T_LF : T_CR;
            T_LF: st_d.ts = push ? T_IDLE : T_LF;
        endcase
        st_d.in_rdy = st_d.ts == T_TAKE && !accept;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rx_byte_valid = st_q.ob_v;
    assign rx_byte_data = st_q.ob_d;
    assign frame_good = st_q.good;
    assign frame_error = st_q.err;
    assign tx_in_ready = st_q.in_rdy;

    ////////////////////////////////////////////////////////////////////
    sequence s_cr_pushed;
        push && st_q.ts == T_CR;
    endsequence
    sequence s_rtu_start;
        st_q.ts == T_IDLE && !ascii_mode ##1 st_q.ts == T_TAKE;
    endsequence

    AST_RESULT_EXCL: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !(frame_good && frame_error))
        else $error("frame both good and bad");
    AST_ASCII_SUM_ZERO: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        frame_good && ascii_mode && $past(ascii_mode) |-> st_q.rsum == 8'h00)
        else $error("text frame accepted with nonzero sum");
    AST_RTU_GAP_CLOSE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !ascii_mode && !$past(ascii_mode) && (frame_good || frame_error)
        |-> $past(st_q.ridle) >= GAP_LIM)
        else $error("binary frame closed before silence");
    AST_TX_GAP_BEFORE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_rtu_start |-> $past(st_q.tidle) > GAP_LIM)
        else $error("binary frame started without silence");
    AST_TX_CRLF: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_cr_pushed |=> st_q.ts == T_LF ##[0:1000] push)
        else $error("LF did not follow CR");
    AST_TX_READY_TAKE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_in_ready |-> st_q.ts == T_TAKE)
        else $error("message byte taken outside take state");
endmodule : serial_frame_check_unit
`default_nettype wire

// *** bench/line_host.sv ***
`default_nettype none
module line_host (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] seen_q[$];
    int stamp_q[$];
    int cyc;
    logic [1:0] stall;
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        cyc = 0;
        stall = 2'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Stalls one cycle in three so the buffer must hold words
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            seen_q.push_back(tx_data);
            stamp_q.push_back(cyc);
        end
        #1;
        stall = (stall == 2'h2) ? 2'h0 : stall + 2'h1;
        tx_ready = rst_n && (stall != 2'h2);
    end
    ////////////////////////////////////////////////////////////////////////
    // Idle data line shows the inverse of the last byte
    task automatic send_chars(input logic [7:0] q[$], input int space);
        foreach (q[i]) begin
            @(posedge ref_clk);
            #1;
            rx_valid = 1'b1;
            rx_data = q[i];
            @(posedge ref_clk);
            #1;
            rx_valid = 1'b0;
            rx_data = ~q[i];
            repeat (space - 1) @(posedge ref_clk);
        end
    endtask : send_chars
endmodule : line_host
`default_nettype wire

// *** bench/tb.sv ***
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP = 20;
    logic ref_clk = 1'b0, rst_n = 1'b0, ascii_mode = 1'b1;
    logic tx_in_valid = 1'b0, tx_in_last = 1'b0;
    logic [7:0] tx_in_data = 8'h00;
    logic rx_valid, tx_ready, tx_valid, rx_byte_valid;
    logic frame_good, frame_error, tx_in_ready;
    logic [7:0] rx_data, tx_data, rx_byte_data;
    int miscompares = 0, checked = 0, good_cnt = 0, err_cnt = 0;
    logic [7:0] got_q[$];
    always #20 ref_clk = ~ref_clk;

    serial_frame_check_unit #(.GAP_CYCLES(GAP)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .ascii_mode(ascii_mode),
        .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_byte_valid(rx_byte_valid), .rx_byte_data(rx_byte_data),
        .frame_good(frame_good), .frame_error(frame_error),
        .tx_in_valid(tx_in_valid), .tx_in_data(tx_in_data),
        .tx_in_last(tx_in_last), .tx_in_ready(tx_in_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    line_host host_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data));

    always @(posedge ref_clk) begin
        if (rx_byte_valid === 1'b1) got_q.push_back(rx_byte_data);
        if (frame_good === 1'b1) good_cnt++;
        if (frame_error === 1'b1) err_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check8
    task automatic cmp_q(string what, logic [7:0] exp[$], logic [7:0] got[$]);
        check8({what, " count"}, 8'(exp.size()), 8'(got.size()));
        foreach (exp[i]) if (i < got.size()) check8(what, exp[i], got[i]);
    endtask : cmp_q
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lrc(logic [7:0] q[$]);
        logic [7:0] s;
        s = 8'h00;
        foreach (q[i]) s = s + q[i];
        return 8'h00 - s;
    endfunction : lrc
    function automatic logic [15:0] crc(logic [7:0] q[$]);
        logic [15:0] r;
        r = 16'hffff;
        foreach (q[i]) begin
            r = r ^ {8'h00, q[i]};
            repeat (8) r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
        end
        return r;
    endfunction : crc
    function automatic logic [7:0] hexc(logic [3:0] n);
        return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction : hexc
    function automatic void add_hex(ref logic [7:0] q[$], input logic [7:0] b);
        q.push_back(hexc(b[7:4]));
        q.push_back(hexc(b[3:0]));
    endfunction : add_hex
    ////////////////////////////////////////////////////////////////////////
    task automatic tx_send(logic [7:0] msg[$]);
        int n;
        foreach (msg[i]) begin
            tx_in_valid = 1'b1;
            tx_in_data = msg[i];
            tx_in_last = (i == msg.size() - 1);
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (tx_in_ready !== 1'b1 && n < 2000);
            #1;
        end
        tx_in_valid = 1'b0;
        tx_in_last = 1'b0;
    endtask : tx_send
    task automatic wait_chars(int n);
        int k;
        k = 0;
        while (host_u.seen_q.size() < n && k < 1000) begin
            @(posedge ref_clk);
            k++;
        end
        #1;
    endtask : wait_chars
    ////////////////////////////////////////////////////////////////////////
    // Text receive: good, bad check, restart on colon
    task automatic t_text_rx();
        logic [7:0] msg[$] = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h02};
        logic [7:0] q[$], ex[$];
        int g, e;
        for (int pass = 0; pass < 3; pass++) begin
            q = '{};
            if (pass == 2) q = '{8'h3a, 8'h35, 8'h35};
            q.push_back(8'h3a);
            foreach (msg[i]) add_hex(q, msg[i]);
            add_hex(q, lrc(msg) ^ ((pass == 1) ? 8'h01 : 8'h00));
            q.push_back(8'h0d);
            q.push_back(8'h0a);
            // Lower case hex on the last pass
            foreach (q[i]) if (pass == 2 && q[i] >= 8'h41 && q[i] <= 8'h46)
                q[i] = q[i] + 8'h20;
            got_q = '{};
            g = good_cnt;
            e = err_cnt;
            host_u.send_chars(q, 2);
            repeat (4) @(posedge ref_clk);
            #1;
            ex = msg;
            ex.push_back(lrc(msg) ^ ((pass == 1) ? 8'h01 : 8'h00));
            cmp_q("text rx bytes", ex, got_q[$-6:$]);
            check8("text good", (pass == 1) ? 8'h00 : 8'h01,
                8'(good_cnt - g));
            check8("text error", (pass == 1) ? 8'h01 : 8'h00,
                8'(err_cnt - e));
        end
    endtask : t_text_rx
    ////////////////////////////////////////////////////////////////////////
    // Text transmit under receiver stalls
    task automatic t_text_tx();
        logic [7:0] msg[$] = '{8'h7f, 8'h03, 8'h05, 8'hc4, 8'h00, 8'h01};
        logic [7:0] ex[$] = '{8'h3a};
        foreach (msg[i]) add_hex(ex, msg[i]);
        add_hex(ex, 8'hb4);
        ex.push_back(8'h0d);
        ex.push_back(8'h0a);
        host_u.seen_q = '{};
        host_u.stamp_q = '{};
        tx_send(msg);
        wait_chars(ex.size());
        cmp_q("text tx line", ex, host_u.seen_q);
    endtask : t_text_tx
    ////////////////////////////////////////////////////////////////////////
    // Binary transmit, two frames back to back
    task automatic t_rtu_tx();
        logic [7:0] msg[$] = '{8'h01, 8'h03, 8'h01, 8'h01, 8'h00, 8'h02};
        logic [7:0] ex[$];
        int gap;
        ascii_mode = 1'b0;
        ex = {msg, 8'h94, 8'h37, msg, 8'h94, 8'h37};
        host_u.seen_q = '{};
        host_u.stamp_q = '{};
        tx_send(msg);
        // Valid low for one edge between messages
        @(posedge ref_clk);
        #1;
        tx_send(msg);
        wait_chars(16);
        cmp_q("rtu tx line", ex, host_u.seen_q);
        gap = host_u.stamp_q[8] - host_u.stamp_q[7];
        check8("rtu tx gap over", 8'h01, 8'(gap > GAP + 1));
    endtask : t_rtu_tx
    ////////////////////////////////////////////////////////////////////////
    // Binary receive: good frame, corrupted frame
    task automatic t_rtu_rx();
        logic [7:0] q[$];
        logic [15:0] c;
        int g, e, n;
        for (int pass = 0; pass < 2; pass++) begin
            q = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h02};
            c = crc(q);
            q.push_back(c[7:0] ^ ((pass == 1) ? 8'h10 : 8'h00));
            q.push_back(c[15:8]);
            got_q = '{};
            g = good_cnt;
            e = err_cnt;
            repeat (GAP + 4) @(posedge ref_clk);
            host_u.send_chars(q, 10);
            n = 0;
            while (good_cnt == g && err_cnt == e && n < GAP + 40) begin
                @(posedge ref_clk);
                #1;
                n++;
            end
            // close only after the silent gap
            check8("rtu close late", 8'h01, 8'(n >= GAP - 7));
            cmp_q("rtu rx bytes", q, got_q);
            check8("rtu good", (pass == 1) ? 8'h00 : 8'h01,
                8'(good_cnt - g));
            check8("rtu error", (pass == 1) ? 8'h01 : 8'h00,
                8'(err_cnt - e));
        end
    endtask : t_rtu_rx
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        $display("FAIL watchdog expected done seen hang");
        stop_test();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        @(posedge ref_clk);
        #1;
        t_text_rx();
        t_text_tx();
        t_rtu_tx();
        t_rtu_rx();
        stop_test();
    end
endmodule : tb
`default_nettype wire
